// ===== src/cmdec_top.sv
// Control-memory decoder: maps host slave accesses onto SRAM, local bus
// and on-chip tables. Assumes one host request at a time, held until done.
// Notes on behaviour
// (R1) Local-bus access waits for peripheral ready.
// (R2) Local-bus cycles start only from host slave.
// (R3) Local-bus address is host address bits 13-2.
// (R4) Peripheral selects at 0A000 and 0B000 windows.
// (R5) Scheduler table at words 00000-007FF.
// (R6) Active-packet counters at words 00800-00BFF.
// (R7) Free-buffer ring pointers at 00E00-00FFF.
// (R8) DMA state table at words 01000-08FFF.
// (R9) Word address is byte offset over four.
// (R10) SRAM cycle suits 15 ns parts.
// (R11) System needs 64K SRAM for full channels.
// (R12) Ring cache and lookup table on chip.
// (R13) Low/high space selects, active low, exclusive.
// (R14) Bank select follows word address bit 15.
// (R15) Whole-word writes; no enables means unchanged.
// (R16) Reserved regions: writes ignored, reads zero.
`timescale 1ns/1ps
`default_nettype none
module cmdec_top (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic nrst,
   // Host slave request port.
   input wire logic host_req,
   input wire logic host_wr,
   input wire logic [18:0] host_addr,
   input wire logic [3:0] host_be,
   input wire logic [31:0] host_wdata,
   output logic host_done,
   output logic [31:0] host_rdata,
   // Control-memory SRAM port.
   output logic [15:0] ctrl_mem_addr,
   output logic ctrl_mem_low_space_sel_n,
   output logic ctrl_mem_high_space_sel_n,
   output logic sram_bank_a_sel_n,
   output logic sram_bank_b_sel_n,
   output logic ctrl_mem_we_n,
   output logic ctrl_mem_oe_n,
   output logic [31:0] ctrl_mem_dout,
   output logic ctrl_mem_dout_en_n,
   input wire logic [31:0] ctrl_mem_din,
   // Local peripheral bus.
   output logic [11:0] local_addr,
   output logic local_periph_sel_a,
   output logic local_periph_sel_b,
   output logic local_wr,
   output logic [31:0] local_wdata,
   input wire logic [31:0] local_rdata,
   input wire logic local_ready
);
   // ==========================================================
   // Decode of the incoming request.
   logic [16:0] waddr;
   logic in_sram, in_fbc, in_dlu, in_lpa, in_lpb, wr_eff;
   assign waddr = host_addr[18:2]; // [R9]
   assign wr_eff = host_wr & (|host_be); // [R15]
   // SRAM holds scheduler, counters, ring pointers, DMA state and the
   // coprocessor space. [R5] [R6] [R7] [R8]
   assign in_sram = (waddr <= cmdec_pkg::APC_LAST)
      || (waddr >= cmdec_pkg::FBP_BASE && waddr <= cmdec_pkg::DMAS_LAST)
      || (waddr >= cmdec_pkg::COP_BASE);
   assign in_fbc = (waddr >= cmdec_pkg::FBC_BASE) && (waddr <= cmdec_pkg::FBC_LAST);
   assign in_dlu = (waddr >= cmdec_pkg::DLU_BASE) && (waddr <= cmdec_pkg::DLU_LAST);
   assign in_lpa = (waddr >= cmdec_pkg::LPA_BASE) && (waddr <= cmdec_pkg::LPA_LAST); // [R4]
   assign in_lpb = (waddr >= cmdec_pkg::LPB_BASE) && (waddr <= cmdec_pkg::LPB_LAST); // [R4]

   // ==========================================================
   // State and latched access.
   cmdec_pkg::cmdec_state_t state_ff, nxt_state;
   logic [16:0] waddr_ff;
   logic wr_ff;
   logic [31:0] wdata_ff;
   logic [1:0] cnt_ff;
   logic sel_fbc_ff, sel_dlu_ff;
   // A request still high while done shows is the old one, not a new one. [R2]
   logic take;
   assign take = (state_ff == cmdec_pkg::ST_IDLE) && host_req && !host_done;

   // Next-state logic; unmapped regions go straight to done. [R16]
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         cmdec_pkg::ST_IDLE: begin
            if (take) begin // [R2]
               if (in_sram) begin
                  nxt_state = cmdec_pkg::ST_SRAM;
               end else if (in_lpa || in_lpb) begin
                  nxt_state = cmdec_pkg::ST_LBUS;
               end else if (in_fbc || in_dlu) begin
                  nxt_state = cmdec_pkg::ST_INT;
               end else begin
                  nxt_state = cmdec_pkg::ST_DONE;
               end
            end
         end
         cmdec_pkg::ST_SRAM: begin
            if (cnt_ff == 2'(cmdec_pkg::SRAM_CYC)) begin // [R10]
               nxt_state = cmdec_pkg::ST_DONE;
            end
         end
         cmdec_pkg::ST_LBUS: begin
            if (local_ready) begin // [R1]
               nxt_state = cmdec_pkg::ST_DONE;
            end
         end
         cmdec_pkg::ST_INT: nxt_state = cmdec_pkg::ST_DONE;
         cmdec_pkg::ST_DONE: nxt_state = cmdec_pkg::ST_IDLE;
         default: nxt_state = cmdec_pkg::ST_IDLE;
      endcase
   end

   // State register.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         state_ff <= cmdec_pkg::ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Capture the request once, so the pins stay stable through the cycle.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         waddr_ff <= 17'h0_0000;
         wr_ff <= 1'b0;
         wdata_ff <= 32'h0000_0000;
         sel_fbc_ff <= 1'b0;
         sel_dlu_ff <= 1'b0;
      end else if (take) begin
         waddr_ff <= waddr;
         wr_ff <= wr_eff;
         wdata_ff <= host_wdata;
         sel_fbc_ff <= in_fbc;
         sel_dlu_ff <= in_dlu;
      end
   end

   // SRAM wait counter; at 50 ns per cycle one cycle covers a 15 ns part.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         cnt_ff <= 2'h0;
      end else if (state_ff == cmdec_pkg::ST_SRAM) begin
         cnt_ff <= cnt_ff + 2'h1;
      end else begin
         cnt_ff <= 2'h0;
      end
   end

   // ==========================================================
   // External SRAM pins.
   logic sram_act, hi_sp;
   assign sram_act = (state_ff == cmdec_pkg::ST_SRAM);
   assign hi_sp = waddr_ff[16];
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_mem_low_space_sel_n <= 1'b1;
         ctrl_mem_high_space_sel_n <= 1'b1;
         sram_bank_a_sel_n <= 1'b1;
         sram_bank_b_sel_n <= 1'b1;
         ctrl_mem_we_n <= 1'b1;
         ctrl_mem_oe_n <= 1'b1;
         ctrl_mem_dout_en_n <= 1'b1;
         ctrl_mem_addr <= 16'h0000;
         ctrl_mem_dout <= 32'h0000_0000;
      end else begin
         // Selects only while a cycle runs; only one space at a time. [R13]
         ctrl_mem_low_space_sel_n <= ~(sram_act & ~hi_sp); // [R13]
         ctrl_mem_high_space_sel_n <= ~(sram_act & hi_sp); // [R13]
         sram_bank_a_sel_n <= ~(sram_act & ~hi_sp & ~waddr_ff[cmdec_pkg::BANK_BIT]); // [R14]
         sram_bank_b_sel_n <= ~(sram_act & ~hi_sp & waddr_ff[cmdec_pkg::BANK_BIT]); // [R14]
         // Write strobe drops one cycle early so data holds past its edge.
         ctrl_mem_we_n <= ~(sram_act & wr_ff & (nxt_state == cmdec_pkg::ST_SRAM)); // [R15]
         ctrl_mem_oe_n <= ~(sram_act & ~wr_ff);
         ctrl_mem_dout_en_n <= ~(sram_act & wr_ff);
         ctrl_mem_addr <= waddr_ff[15:0];
         ctrl_mem_dout <= wdata_ff;
      end
   end

   // ==========================================================
   // Local peripheral bus pins; address comes from host bits 13-2.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         local_addr <= 12'h000;
         local_periph_sel_a <= 1'b0;
         local_periph_sel_b <= 1'b0;
         local_wr <= 1'b0;
         local_wdata <= 32'h0000_0000;
      end else if (take && (in_lpa || in_lpb)) begin
         local_addr <= host_addr[cmdec_pkg::LB_ADDR_LSB +: cmdec_pkg::LB_ADDR_W]; // [R3]
         local_periph_sel_a <= in_lpa; // [R2] [R4]
         local_periph_sel_b <= in_lpb; // [R4]
         local_wr <= wr_eff;
         local_wdata <= host_wdata;
      end else if (state_ff == cmdec_pkg::ST_LBUS && local_ready) begin
         local_periph_sel_a <= 1'b0; // [R1]
         local_periph_sel_b <= 1'b0;
         local_wr <= 1'b0;
      end
   end

   // ==========================================================
   // On-chip tables: ring cache and DMA lookup. [R12]
   logic [31:0] fbc_rd, dlu_rd;
   logic int_wr;
   assign int_wr = (state_ff == cmdec_pkg::ST_INT) & wr_ff;
   cmdec_onchip_mem #(.DEPTH(cmdec_pkg::FBC_DEPTH), .AW(4)) u_fbc (
      .sys_clk(sys_clk),
      .wr_en(int_wr & sel_fbc_ff),
      .addr(waddr_ff[3:0]),
      .wdata(wdata_ff),
      .rdata(fbc_rd)
   );
   cmdec_onchip_mem #(.DEPTH(cmdec_pkg::DLU_DEPTH), .AW(12)) u_dlu (
      .sys_clk(sys_clk),
      .wr_en(int_wr & sel_dlu_ff),
      .addr(waddr_ff[11:0]),
      .wdata(wdata_ff),
      .rdata(dlu_rd)
   );

   // ==========================================================
   // Read data and completion; reserved space reads zero. [R16]
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         host_rdata <= cmdec_pkg::RD_ZERO;
      end else if (nxt_state == cmdec_pkg::ST_DONE && state_ff != cmdec_pkg::ST_DONE) begin
         case (state_ff)
            cmdec_pkg::ST_SRAM: host_rdata <= ctrl_mem_din;
            cmdec_pkg::ST_LBUS: host_rdata <= local_rdata; // [R1]
            default: host_rdata <= cmdec_pkg::RD_ZERO; // [R16]
         endcase
      end else if (state_ff == cmdec_pkg::ST_DONE && sel_fbc_ff) begin
         host_rdata <= fbc_rd; // [R12]
      end else if (state_ff == cmdec_pkg::ST_DONE && sel_dlu_ff) begin
         host_rdata <= dlu_rd; // [R12]
      end
   end

   // Completion flag is registered so it aligns with the read data.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         host_done <= 1'b0;
      end else begin
         host_done <= (state_ff == cmdec_pkg::ST_DONE);
      end
   end
endmodule
`default_nettype wire

// ===== src/cmdec_pkg.sv
// Constants for the control-memory and local-bus decoder.
// Assumes a 32-bit host slave port with a word-aligned byte offset.
package cmdec_pkg;
   // ==========================================================
   // Word address map of the control memory (17-bit word space).
   localparam logic [16:0] SCHED_BASE = 17'h0_0000;
   localparam logic [16:0] SCHED_LAST = 17'h0_07FF;
   localparam logic [16:0] APC_BASE = 17'h0_0800;
   localparam logic [16:0] APC_LAST = 17'h0_0BFF;
   localparam logic [16:0] FBC_BASE = 17'h0_0C00;
   localparam logic [16:0] FBC_LAST = 17'h0_0C0D;
   localparam logic [16:0] FBP_BASE = 17'h0_0E00;
   localparam logic [16:0] FBP_LAST = 17'h0_0FFF;
   localparam logic [16:0] DMAS_BASE = 17'h0_1000;
   localparam logic [16:0] DMAS_LAST = 17'h0_8FFF;
   localparam logic [16:0] DLU_BASE = 17'h0_9000;
   localparam logic [16:0] DLU_LAST = 17'h0_9FFF;
   localparam logic [16:0] LPA_BASE = 17'h0_A000;
   localparam logic [16:0] LPA_LAST = 17'h0_AFFF;
   localparam logic [16:0] LPB_BASE = 17'h0_B000;
   localparam logic [16:0] LPB_LAST = 17'h0_BFFF;
   localparam logic [16:0] COP_BASE = 17'h1_0000;
   // ==========================================================
   // Field positions and widths.
   localparam int BANK_BIT = 15;
   localparam int LB_ADDR_W = 12;
   localparam int LB_ADDR_LSB = 2;
   localparam int FBC_DEPTH = 14;
   localparam int DLU_DEPTH = 4096;
   // ==========================================================
   // SRAM timing: access time in ns, clock period in ns.
   localparam int SRAM_TACC_NS = 15;
   localparam int CLK_PERIOD_NS = 50;
   localparam int SRAM_CYC = (SRAM_TACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [31:0] RD_ZERO = 32'h0000_0000;
   // Decoder states.
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_SRAM = 3'b001,
      ST_LBUS = 3'b010,
      ST_INT = 3'b011,
      ST_DONE = 3'b100
   } cmdec_state_t;
endpackage

// ===== src/cmdec_onchip_mem.sv
// On-chip word store for the regions that never reach external SRAM.
// Assumes the caller presents one access per cycle on the system clock.
`timescale 1ns/1ps
`default_nettype none
module cmdec_onchip_mem #(
   parameter int DEPTH = 16,
   parameter int AW = 4
) (
   // Clock.
   input wire logic sys_clk,
   // Access port.
   input wire logic wr_en,
   input wire logic [AW-1:0] addr,
   input wire logic [31:0] wdata,
   output logic [31:0] rdata
);
   // ==========================================================
   // Storage array; contents are undefined until software loads them.
   logic [31:0] mem [DEPTH];

   // Synchronous write and registered read.
   always_ff @(posedge sys_clk) begin
      if (wr_en) begin
         mem[addr] <= wdata;
      end
      rdata <= mem[addr];
   end
endmodule
`default_nettype wire

// ===== verif/cmdec_checker.sv
// Port checker for the control-memory decoder.
// Assumes a bind to cmdec_top with one host request held until done.
`timescale 1ns/1ps
`default_nettype none
module cmdec_checker (
   // Clock, reset and host side.
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic host_req,
   input wire logic host_wr,
   input wire logic [18:0] host_addr,
   input wire logic [3:0] host_be,
   input wire logic host_done,
   // Memory and local bus side.
   input wire logic [15:0] ctrl_mem_addr,
   input wire logic ctrl_mem_low_space_sel_n,
   input wire logic ctrl_mem_high_space_sel_n,
   input wire logic sram_bank_a_sel_n,
   input wire logic sram_bank_b_sel_n,
   input wire logic ctrl_mem_we_n,
   input wire logic [11:0] local_addr,
   input wire logic local_periph_sel_a,
   input wire logic local_periph_sel_b,
   input wire logic local_wr,
   input wire logic local_ready
);
   // ==========================================================
   // Helpers: word address, active-high selects, pinless regions.
   wire logic [16:0] w = host_addr[18:2];
   wire logic lo = !ctrl_mem_low_space_sel_n;
   wire logic hi = !ctrl_mem_high_space_sel_n;
   wire logic ls = local_periph_sel_a || local_periph_sel_b;
   wire logic quiet = (w >= cmdec_pkg::FBC_BASE && w < cmdec_pkg::FBP_BASE)
      || (w >= cmdec_pkg::DLU_BASE && w < cmdec_pkg::LPA_BASE)
      || (w > cmdec_pkg::LPB_LAST && w < cmdec_pkg::COP_BASE);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   // ==========================================================
   // Properties.
   property p_laddr; ls |-> local_addr == host_addr[13:2]; endproperty
   a_laddr: assert property (p_laddr) else $error("local address wrong");
   property p_lwin;
      ls |-> host_req && !(local_periph_sel_a && local_periph_sel_b)
         && w[16:12] == (local_periph_sel_a ? 5'h0A : 5'h0B);
   endproperty
   a_lwin: assert property (p_lwin) else $error("peripheral select wrong");
   property p_lwait; ls && !local_ready |=> $stable({local_periph_sel_a, local_periph_sel_b}); endproperty
   a_lwait: assert property (p_lwait) else $error("select left before ready");
   property p_ldone; ls && local_ready |=> !ls ##1 host_done; endproperty
   a_ldone: assert property (p_ldone) else $error("local access not closed");
   property p_lo; lo |-> !hi && !host_addr[18] && ctrl_mem_addr == host_addr[17:2]; endproperty
   a_lo: assert property (p_lo) else $error("low space select wrong");
   property p_hi; hi |-> host_addr[18] && sram_bank_a_sel_n && sram_bank_b_sel_n; endproperty
   a_hi: assert property (p_hi) else $error("high space select wrong");
   property p_bank;
      lo |-> sram_bank_a_sel_n == ctrl_mem_addr[15] && sram_bank_b_sel_n == !ctrl_mem_addr[15];
   endproperty
   a_bank: assert property (p_bank) else $error("bank select wrong");
   property p_quiet; host_req && quiet |-> !lo && !hi && !ls; endproperty
   a_quiet: assert property (p_quiet) else $error("pins moved for internal word");
   property p_nobe; host_req && host_wr && host_be == 4'h0 |-> ctrl_mem_we_n && !local_wr; endproperty
   a_nobe: assert property (p_nobe) else $error("write without enables");
   // Coverage of the slow peripheral, the upper space and an empty write.
   c_lwait: cover property (ls && !local_ready ##1 local_ready);
   c_hi: cover property (hi);
   c_nobe: cover property (host_req && host_wr && host_be == 4'h0);
endmodule
`default_nettype wire

// ===== verif/cmdec_far_side.sv
// Far-side model: asynchronous SRAM for both spaces and two local peripherals.
// Assumes sys_clk is the only clock; lat sets the peripheral ready wait.
`timescale 1ns/1ps
`default_nettype none
module cmdec_far_side (
   // Clock and wait setting.
   input wire logic sys_clk,
   input wire logic [3:0] lat,
   // Memory pins.
   input wire logic [15:0] ctrl_mem_addr,
   input wire logic ctrl_mem_low_space_sel_n,
   input wire logic ctrl_mem_high_space_sel_n,
   input wire logic ctrl_mem_we_n,
   input wire logic ctrl_mem_oe_n,
   input wire logic [31:0] ctrl_mem_dout,
   input wire logic ctrl_mem_dout_en_n,
   output logic [31:0] ctrl_mem_din,
   // Local bus pins.
   input wire logic [11:0] local_addr,
   input wire logic local_periph_sel_a,
   input wire logic local_periph_sel_b,
   input wire logic local_wr,
   input wire logic [31:0] local_wdata,
   output logic [31:0] local_rdata,
   output logic local_ready
);
   logic [31:0] mem [0:131071];
   logic [31:0] lmem [0:8191];
   logic [3:0] cnt = 4'h0;
   logic tog = 1'b0;
   wire logic [16:0] key = {ctrl_mem_low_space_sel_n, ctrl_mem_addr};
   wire logic cs = !(ctrl_mem_low_space_sel_n && ctrl_mem_high_space_sel_n);
   wire logic ls = local_periph_sel_a || local_periph_sel_b;
   wire logic [12:0] lkey = {local_periph_sel_b, local_addr};
   // Full 128K words, so either SRAM size and the upper space hold data.
   // Reads answer at once, as a fast part would; idle lines toggle so stale data shows.
   assign ctrl_mem_din = (cs && !ctrl_mem_oe_n) ? mem[key] : {32{tog}} ^ 32'hA5A5_5A5A;
   assign local_ready = ls && cnt == lat;
   assign local_rdata = local_ready ? lmem[lkey] : {32{tog}} ^ 32'h5A5A_A5A5;
   // Writes land on the clock; the wait counter runs only while selected.
   always @(posedge sys_clk) begin
      tog <= !tog;
      cnt <= ls ? cnt + 4'h1 : 4'h0;
      // Data that the design does not drive lands inverted, so a missing enable shows.
      if (cs && !ctrl_mem_we_n) mem[key] <= ctrl_mem_dout_en_n ? ~ctrl_mem_dout : ctrl_mem_dout;
      if (local_ready && local_wr) lmem[lkey] <= local_wdata;
   end
endmodule
`default_nettype wire

// ===== verif/testbench.sv
// Self-checking bench for the control-memory decoder.
// Assumes the far-side model and the bound checker sit beside the design.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
   $display("wrong value at %0t: got %h want %h", $time, g, e); end end
module testbench;
   typedef struct {logic wr; logic [18:0] a; logic [3:0] be; logic [31:0] d; logic [5:0] m;} cmdec_row_t;
   logic sys_clk = 1'b0, nrst = 1'b0, host_req = 1'b0, host_wr = 1'b0;
   logic [18:0] host_addr = 19'h0_0000;
   logic [3:0] host_be = 4'h0, lat = 4'h0;
   logic [31:0] host_wdata = 32'h0000_0000, host_rdata, ctrl_mem_dout, ctrl_mem_din;
   logic [31:0] local_wdata, local_rdata;
   logic host_done, ctrl_mem_low_space_sel_n, ctrl_mem_high_space_sel_n, sram_bank_a_sel_n;
   logic sram_bank_b_sel_n, ctrl_mem_we_n, ctrl_mem_oe_n, ctrl_mem_dout_en_n, local_ready;
   logic local_periph_sel_a, local_periph_sel_b, local_wr;
   logic [15:0] ctrl_mem_addr;
   logic [11:0] local_addr;
   logic [5:0] seen = 6'h00;
   int n_errors = 0, comparisons = 0, k_last, k0;
   // Rows: write data or expected read data, and the exact set of selects the access must raise.
   cmdec_row_t rows[] = '{
      '{1, 19'h0_1FFC, 4'hF, 32'h1111_0001, 6'h28}, '{1, 19'h0_1FFC, 4'h0, 32'hDEAD_0000, 6'h28},
      '{0, 19'h0_1FFC, 4'hF, 32'h1111_0001, 6'h28}, '{1, 19'h0_2FFC, 4'h1, 32'h2222_0002, 6'h28},
      '{0, 19'h0_2FFC, 4'hF, 32'h2222_0002, 6'h28}, '{1, 19'h0_3800, 4'hF, 32'h3333_0003, 6'h28},
      '{1, 19'h2_3FFC, 4'hF, 32'h4444_0004, 6'h24}, '{0, 19'h2_3FFC, 4'hF, 32'h4444_0004, 6'h24},
      '{1, 19'h0_3034, 4'hF, 32'h5555_0005, 6'h00}, '{0, 19'h0_3034, 4'hF, 32'h5555_0005, 6'h00},
      '{1, 19'h2_7FFC, 4'hF, 32'h6666_0006, 6'h00}, '{0, 19'h2_7FFC, 4'hF, 32'h6666_0006, 6'h00},
      '{1, 19'h3_FFFC, 4'hF, 32'h7777_0007, 6'h00}, '{0, 19'h3_FFFC, 4'hF, 32'h0000_0000, 6'h00},
      '{1, 19'h2_8004, 4'hF, 32'h8888_0008, 6'h02}, '{0, 19'h2_8004, 4'hF, 32'h8888_0008, 6'h02},
      '{1, 19'h2_FFFC, 4'hF, 32'h9999_0009, 6'h01}, '{0, 19'h2_FFFC, 4'hF, 32'h9999_0009, 6'h01},
      '{1, 19'h7_FFFC, 4'hF, 32'hAAAA_000A, 6'h10}, '{0, 19'h7_FFFC, 4'hF, 32'hAAAA_000A, 6'h10}};
   cmdec_top i_cmdec_top (.sys_clk, .nrst, .host_req, .host_wr, .host_addr, .host_be,
      .host_wdata, .host_done, .host_rdata, .ctrl_mem_addr, .ctrl_mem_low_space_sel_n,
      .ctrl_mem_high_space_sel_n, .sram_bank_a_sel_n, .sram_bank_b_sel_n, .ctrl_mem_we_n,
      .ctrl_mem_oe_n, .ctrl_mem_dout, .ctrl_mem_dout_en_n, .ctrl_mem_din, .local_addr,
      .local_periph_sel_a, .local_periph_sel_b, .local_wr, .local_wdata, .local_rdata, .local_ready);
   cmdec_far_side i_cmdec_far_side (.sys_clk, .lat, .ctrl_mem_addr, .ctrl_mem_low_space_sel_n,
      .ctrl_mem_high_space_sel_n, .ctrl_mem_we_n, .ctrl_mem_oe_n, .ctrl_mem_dout, .ctrl_mem_din,
      .local_addr, .local_periph_sel_a, .local_periph_sel_b, .local_wr, .local_wdata,
      .local_rdata, .local_ready, .ctrl_mem_dout_en_n);
   // Clock of 50 ns.
   always #25 sys_clk = !sys_clk;
   // Collect every select raised while a request is open.
   always @(posedge sys_clk) seen <= host_req ? seen | {!ctrl_mem_low_space_sel_n,
      !ctrl_mem_high_space_sel_n, !sram_bank_a_sel_n, !sram_bank_b_sel_n,
      local_periph_sel_a, local_periph_sel_b} : 6'h00;
   // Prints the counts and the verdict, then stops.
   task automatic complete_run();
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // One host access. The request stands until the rising edge at which done is seen
   // high and drops on that edge; the design ignores a request seen beside done.
   task automatic acc(input cmdec_row_t r);
      int k;
      k = 0;
      @(posedge sys_clk);
      host_req <= 1'b1;
      host_wr <= r.wr;
      host_addr <= r.a;
      host_be <= r.be;
      host_wdata <= r.d;
      do begin
         @(posedge sys_clk);
         k++;
      end while (host_done !== 1'b1 && k < 60);
      host_req <= 1'b0;
      k_last = k;
      if (k == 60) begin
         n_errors++;
         complete_run();
      end
      if (!r.wr) `CHK(host_rdata, r.d)
      if (!r.wr || r.be != 4'h0) `CHK(seen, r.m)
   endtask
   // Reset, the table, then a slow peripheral.
   initial begin
      repeat (20) @(posedge sys_clk);
      `CHK({ctrl_mem_low_space_sel_n, ctrl_mem_high_space_sel_n, sram_bank_a_sel_n, sram_bank_b_sel_n, local_periph_sel_a, local_periph_sel_b, host_done}, 7'h78)
      nrst <= 1'b1;
      foreach (rows[i]) acc(rows[i]);
      acc(rows[15]);
      k0 = k_last;
      @(posedge sys_clk) lat <= 4'h6;
      acc(rows[15]);
      `CHK(k_last - k0, 6)
      // Reset in mid-run: pins go idle and read data clears, then SRAM still answers.
      @(posedge sys_clk) nrst <= 1'b0;
      @(posedge sys_clk);
      `CHK({ctrl_mem_low_space_sel_n, ctrl_mem_high_space_sel_n, sram_bank_a_sel_n, sram_bank_b_sel_n, local_periph_sel_a, local_periph_sel_b, host_done, host_rdata}, {7'h78, 32'h0000_0000})
      @(posedge sys_clk) nrst <= 1'b1;
      acc(rows[2]);
      complete_run();
   end
endmodule
bind cmdec_top cmdec_checker i_cmdec_checker (.sys_clk, .nrst, .host_req, .host_wr,
   .host_addr, .host_be, .host_done, .ctrl_mem_addr, .ctrl_mem_low_space_sel_n,
   .ctrl_mem_high_space_sel_n, .sram_bank_a_sel_n, .sram_bank_b_sel_n, .ctrl_mem_we_n,
   .local_addr, .local_periph_sel_a, .local_periph_sel_b, .local_wr, .local_ready);
`default_nettype wire
